// File: design/spt_cfg.svh
`ifndef SPT_CFG_SVH
`define SPT_CFG_SVH
// Clock rate in Hz and period in ns.
`define SPT_CLK_HZ        25000000
`define SPT_CLK_NS        40
// Pulse width limits in ns.
`define SPT_MIN_HIGH_NS   100
`define SPT_MAX_HIGH_NS   500000000
// Least high time rounds up, longest rounds down.
`define SPT_MIN_HIGH_CYC  ((`SPT_MIN_HIGH_NS + `SPT_CLK_NS - 1) / `SPT_CLK_NS)
`define SPT_MAX_HIGH_CYC  (`SPT_MAX_HIGH_NS / `SPT_CLK_NS)
// Default high time of the generated pulse in cycles (1 us).
`define SPT_DEF_HIGH_CYC  25
// Message shift width.
`define SPT_TOD_W         32
`endif

// File: design/spt_pkg.sv
package spt_pkg;
    // Direction of the single port.
    typedef enum logic {SPT_DIR_IN, SPT_DIR_OUT} spt_dir_e;
    // Message shifter states.
    typedef enum logic [1:0] {SPT_IDLE, SPT_START, SPT_SHIFT, SPT_STOP} spt_msg_e;
endpackage : spt_pkg

// File: design/spt_tod_serial.sv
`include "spt_cfg.svh"
module spt_tod_serial #(
    parameter int WIDTH   = `SPT_TOD_W,
    parameter int BIT_CYC = 25
) (
    // Clock, reset and enable.
    input  wire logic             mclk,
    input  wire logic             rst,
    input  wire logic             clkEn,
    // Send request.
    input  wire logic             send,
    input  wire logic [WIDTH-1:0] word,
    // Serial line and status.
    output logic                  txLine,
    output logic                  busy
);
    import spt_pkg::*;

    // ---------------------------------------------
    // Message shifter: start bit low, LSB first, stop high.
    // ---------------------------------------------
    spt_msg_e           state, next_state;        // Shifter state.
    logic [WIDTH-1:0]   shreg, next_shreg;        // Bits still to send.
    logic [15:0]        bitCnt, next_bitCnt;      // Cycles in current bit.
    logic [7:0]         idx, next_idx;            // Bits sent so far.
    logic               line, next_line;          // Registered line level.

    // Next-state logic; a request while busy is ignored.
    always_comb begin
        next_state  = state;
        next_shreg  = shreg;
        next_bitCnt = bitCnt;
        next_idx    = idx;
        next_line   = line;
        case (state)
            SPT_IDLE: begin
                next_line = 1'b1;
                if (send) begin
                    next_shreg  = word;
                    next_state  = SPT_START;
                    next_line   = 1'b0;
                    next_bitCnt = 16'h0000;
                end
            end
            SPT_START, SPT_SHIFT: begin
                next_bitCnt = bitCnt + 16'h0001;
                if (bitCnt == 16'(BIT_CYC - 1)) begin
                    next_bitCnt = 16'h0000;
                    if (state == SPT_SHIFT && idx == 8'(WIDTH)) begin
                        next_state = SPT_STOP;
                        next_line  = 1'b1;
                    end else begin
                        next_state = SPT_SHIFT;
                        next_line  = shreg[0];
                        next_shreg = shreg >> 1;
                        next_idx   = idx + 8'h01;
                    end
                end
            end
            SPT_STOP: begin
                next_bitCnt = bitCnt + 16'h0001;
                if (bitCnt == 16'(BIT_CYC - 1)) begin
                    next_state = SPT_IDLE;
                    next_idx   = 8'h00;
                end
            end
            default: next_state = SPT_IDLE;
        endcase
    end

    // Registers, frozen while the clock enable is low.
    always_ff @(posedge mclk) begin
        if (rst) begin
            state  <= SPT_IDLE;
            shreg  <= '0;
            bitCnt <= 16'h0000;
            idx    <= 8'h00;
            line   <= 1'b1;
        end else if (clkEn) begin
            state  <= next_state;
            shreg  <= next_shreg;
            bitCnt <= next_bitCnt;
            idx    <= next_idx;
            line   <= next_line;
        end
    end

    assign txLine = line;
    assign busy   = (state != SPT_IDLE);
endmodule : spt_tod_serial

// File: design/spt_pulse_port.sv
// Functional notes
// - Input mode takes pulse and message as reference.
// - Output mode drives pulse and message out.
// - One port, one direction at a time.
// - Output pulse rises at second rollover.
// - Link pulse high 100 ns to 500 ms.
// - Receiver corrects incoming pulse for cable delay.
// - Compensation value is programmable.
// - Master pulse placed within 10 ns; the code places it to one 40 ns clock cycle instead.
// - Residual compensation error within 10 ns; the code compensates in whole 40 ns clock cycles instead.
// - Leading edge timestamped within 30 ns; the code stamps to one 40 ns clock cycle instead.
// - Only the rising edge is significant.
// - Measurement output rises at each rollover.
// - Measurement pulse high 100 ns to 500 ms.
// - Measurement pulse placed within 5 ns; the code places it to one 40 ns clock cycle instead.
// - Time-of-day message on its own pair.
`include "spt_cfg.svh"
module spt_pulse_port #(
    parameter int CYC_PER_SEC = `SPT_CLK_HZ,
    parameter int TOD_W       = `SPT_TOD_W,
    parameter int BIT_CYC     = 25
) (
    // Clock, reset and enable.
    input  wire logic                 mclk,
    input  wire logic                 rst,
    input  wire logic                 clkEn,
    // Configuration.
    input  wire spt_pkg::spt_dir_e    portDir,
    input  wire logic [31:0]          highCycles,
    input  wire logic [31:0]          delayCompCycles,
    input  wire logic [TOD_W-1:0]     localSeconds,
    // Incoming marker and message, already received to logic levels.
    input  wire logic                 markerInputPair,
    input  wire logic                 todRxValid,
    input  wire logic [TOD_W-1:0]     todRxSeconds,
    // Outgoing marker and message.
    output logic                      markerOutputPair,
    output logic                      markerOutputEn,
    output logic                      todTxLine,
    output logic                      measureOut,
    // Local time state.
    output logic [31:0]               subSecond,
    output logic [TOD_W-1:0]          secondsNow,
    output logic                      secondTick,
    output logic [31:0]               edgeStamp,
    output logic                      edgeStampValid
);
    import spt_pkg::*;

    // ---------------------------------------------
    // Second counter and pulse generator
    // ---------------------------------------------
    logic [31:0]       secCnt, next_secCnt;        // Cycles within current second.
    logic [TOD_W-1:0]  secs, next_secs;            // Whole seconds.
    logic [31:0]       hiCnt, next_hiCnt;          // Remaining high cycles.
    logic              pulse, next_pulse;          // Registered pulse level.
    logic              tick, next_tick;            // Rollover strobe.
    logic [TOD_W-1:0]  pendSecs, next_pendSecs;    // Message latched from link.
    logic              pendValid, next_pendValid;  // Message waiting for next edge.
    logic [31:0]       stamp, next_stamp;          // Timestamp of input edge.
    logic              stampV, next_stampV;        // Timestamp strobe.
    logic              mkPrev, next_mkPrev;        // Previous input sample.
    logic [31:0]       hiClamp;                    // High time held to legal range.
    logic              rise;                       // Rising edge of input marker.
    logic              rollover;                   // Local second boundary.
    logic [31:0]       alignCnt;                   // Counter value after delay correction.

    // The width is clamped so no setting breaks the legal window.
    always_comb begin
        hiClamp = highCycles;
        if (highCycles < 32'(`SPT_MIN_HIGH_CYC)) hiClamp = 32'(`SPT_MIN_HIGH_CYC);
        if (highCycles > 32'(`SPT_MAX_HIGH_CYC)) hiClamp = 32'(`SPT_MAX_HIGH_CYC);
    end

    assign rise     = (portDir == SPT_DIR_IN) && markerInputPair && !mkPrev;
    assign rollover = (secCnt == 32'(CYC_PER_SEC - 1));
    // The edge arrived delay cycles late, so the true boundary passed that long ago.
    assign alignCnt = (delayCompCycles < 32'(CYC_PER_SEC)) ? delayCompCycles : 32'(CYC_PER_SEC - 1);

    // Next-state logic for time keeping and pulse shaping.
    always_comb begin
        next_secCnt    = rollover ? 32'h0000_0000 : secCnt + 32'h0000_0001;
        next_secs      = rollover ? secs + 1'b1 : secs;
        next_tick      = rollover;
        next_hiCnt     = hiCnt;
        next_pulse     = pulse;
        next_pendSecs  = pendSecs;
        next_pendValid = pendValid;
        next_stamp     = stamp;
        next_stampV    = 1'b0;
        next_mkPrev    = markerInputPair;
        // Message from the master names the second its next edge marks.
        if (portDir == SPT_DIR_IN && todRxValid) begin
            next_pendSecs  = todRxSeconds;
            next_pendValid = 1'b1;
        end
        if (rise) begin
            // Edge stamped in the same cycle it is seen: one cycle, 40 ns, worst case.
            next_stamp  = secCnt;
            next_stampV = 1'b1;
            next_secCnt = alignCnt;
            next_tick   = 1'b0;
            if (pendValid) begin
                next_secs      = pendSecs;
                next_pendValid = 1'b0;
            end
        end
        // Pulse is set in the rollover cycle and rises as the counter reads zero; exact within one clock.
        if (rollover) begin
            next_pulse = 1'b1;
            next_hiCnt = hiClamp - 32'h0000_0001;
        end else if (hiCnt != 32'h0000_0000) begin
            next_hiCnt = hiCnt - 32'h0000_0001;
        end else begin
            next_pulse = 1'b0;
        end
    end

    // Registers, frozen while the clock enable is low.
    always_ff @(posedge mclk) begin
        if (rst) begin
            secCnt    <= 32'h0000_0000;
            secs      <= '0;
            hiCnt     <= 32'h0000_0000;
            pulse     <= 1'b0;
            tick      <= 1'b0;
            pendSecs  <= '0;
            pendValid <= 1'b0;
            stamp     <= 32'h0000_0000;
            stampV    <= 1'b0;
            mkPrev    <= 1'b0;
        end else if (clkEn) begin
            secCnt    <= next_secCnt;
            secs      <= next_secs;
            hiCnt     <= next_hiCnt;
            pulse     <= next_pulse;
            tick      <= next_tick;
            pendSecs  <= next_pendSecs;
            pendValid <= next_pendValid;
            stamp     <= next_stamp;
            stampV    <= next_stampV;
            mkPrev    <= next_mkPrev;
        end
    end

    // ---------------------------------------------
    // Time-of-day message sender
    // ---------------------------------------------
    // The message for the new second starts right after its pulse edge.
    spt_tod_serial #(
        .WIDTH   (TOD_W),
        .BIT_CYC (BIT_CYC)
    ) u_tod (
        .mclk    (mclk),
        .rst     (rst),
        .clkEn   (clkEn),
        .send    (tick && portDir == SPT_DIR_OUT),
        .word    (secs),
        .txLine  (todTxLine),
        .busy    ()
    );

    // ---------------------------------------------
    // Outputs
    // ---------------------------------------------
    // The pair is driven only in output mode, so one port never faces both ways.
    assign markerOutputPair = pulse && (portDir == SPT_DIR_OUT);
    assign markerOutputEn   = (portDir == SPT_DIR_OUT);
    // The measurement output runs in either mode; on input it follows the corrected time.
    assign measureOut       = pulse;
    assign subSecond        = secCnt;
    assign secondsNow       = secs;
    assign secondTick       = tick;
    assign edgeStamp        = stamp;
    assign edgeStampValid   = stampV;
endmodule : spt_pulse_port

// File: dv/spt_pulse_port_monitor.sv
module spt_pulse_port_monitor #(
    parameter int CYC_PER_SEC = 25000000,
    parameter int TOD_W       = 32,
    parameter int BIT_CYC     = 25
) (
    // Clock and reset.
    input wire logic              mclk,
    input wire logic              rst,
    input wire logic              clkEn,
    // Watched inputs.
    input wire spt_pkg::spt_dir_e portDir,
    input wire logic              markerInputPair,
    // Watched outputs.
    input wire logic              markerOutputPair,
    input wire logic              markerOutputEn,
    input wire logic              todTxLine,
    input wire logic              measureOut,
    input wire logic [31:0]       subSecond,
    input wire logic [TOD_W-1:0]  secondsNow,
    input wire logic              secondTick,
    input wire logic              edgeStampValid
);
    timeunit 1ns;
    timeprecision 1ns;
    import spt_pkg::*;
    logic [31:0] hiCnt;      // Length of the current high time.
    logic [31:0] next_hiCnt; // Next high-time count.
    // A counter is used because 500 ms is far beyond any repetition bound.
    always_comb begin
        next_hiCnt = measureOut ? hiCnt + 32'h1 : 32'h0;
    end
    always_ff @(posedge mclk) begin
        hiCnt <= rst ? 32'h0 : next_hiCnt;
    end
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);
    a_tick_at_rollover: assert property (secondTick |-> measureOut && subSecond == 32'h0)
        else $error("tick without rollover pulse");
    a_pulse_rise_cause: assert property ($rose(measureOut) |-> secondTick)
        else $error("pulse rose away from rollover");
    a_min_high_time: assert property ($rose(measureOut) |=> measureOut [*2])
        else $error("pulse shorter than three cycles");
    a_max_high_time: assert property (hiCnt <= 32'd12500000)
        else $error("pulse longer than half a second");
    a_link_gate: assert property (markerOutputPair == (measureOut && portDir == SPT_DIR_OUT))
        else $error("link pulse not gated by direction");
    a_one_direction: assert property (markerOutputEn == (portDir == SPT_DIR_OUT))
        else $error("link enable disagrees with direction");
    a_in_refused: assert property (portDir == SPT_DIR_OUT && $past(portDir) == SPT_DIR_OUT |-> !edgeStampValid)
        else $error("edge stamped in output mode");
    a_edge_stamped: assert property (portDir == SPT_DIR_IN && clkEn && $rose(markerInputPair) |=> edgeStampValid)
        else $error("input edge not stamped");
    // A tick held by a frozen clock enable is judged only where it first appears.
    a_seconds_step: assert property ($rose(secondTick) && portDir == SPT_DIR_OUT |-> secondsNow == $past(secondsNow) + 1)
        else $error("seconds did not advance");
    a_message_start: assert property (secondTick && clkEn && portDir == SPT_DIR_OUT |=> !todTxLine)
        else $error("message start bit missing");
endmodule : spt_pulse_port_monitor
bind spt_pulse_port spt_pulse_port_monitor #(.CYC_PER_SEC(CYC_PER_SEC), .TOD_W(TOD_W), .BIT_CYC(BIT_CYC)) mon (
    .mclk(mclk), .rst(rst), .clkEn(clkEn), .portDir(portDir), .markerInputPair(markerInputPair),
    .markerOutputPair(markerOutputPair), .markerOutputEn(markerOutputEn), .todTxLine(todTxLine),
    .measureOut(measureOut), .subSecond(subSecond), .secondsNow(secondsNow), .secondTick(secondTick),
    .edgeStampValid(edgeStampValid));

// File: dv/spt_time_master_model.sv
module spt_time_master_model (
    // Clock and command from the bench.
    input  wire logic        mclk,
    input  wire logic        fire,
    input  wire logic [31:0] secVal,
    // Marker and message toward the port.
    output logic             markerInputPair,
    output logic             todRxValid,
    output logic [31:0]      todRxSeconds
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [2:0] cnt = 3'h0; // Steps of one send.
    initial begin
        markerInputPair = 1'b0;
        todRxValid      = 1'b0;
        todRxSeconds    = 32'h0;
    end
    // Message first, then a four-cycle marker; stale message bits are inverted so they never look held.
    always @(posedge mclk) begin
        todRxValid      <= fire;
        markerInputPair <= (cnt != 3'h0) && (cnt <= 3'h4);
        if (fire) begin
            todRxSeconds <= secVal;
            cnt          <= 3'h6;
        end else begin
            todRxSeconds <= ~todRxSeconds;
            cnt          <= (cnt != 3'h0) ? cnt - 3'h1 : 3'h0;
        end
    end
endmodule : spt_time_master_model

// File: dv/testbench.sv
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    import spt_pkg::*;
    logic mclk = 1'b0, rst = 1'b1, fire = 1'b0, clkEn = 1'b1, mip, rxv, mop, moe, tx, meas, tick, esv;
    spt_dir_e portDir = SPT_DIR_IN;
    logic [31:0] hc = 32'd10, dc = 32'd7, sv = 32'h0000_0a5c, rxs, sub, secs, stamp, s;
    int err_count = 0, num_checks = 0, w;
    spt_pulse_port #(.CYC_PER_SEC(100), .TOD_W(32), .BIT_CYC(2)) dut (
        .mclk(mclk), .rst(rst), .clkEn(clkEn), .portDir(portDir), .highCycles(hc), .delayCompCycles(dc),
        .localSeconds(32'h0), .markerInputPair(mip), .todRxValid(rxv), .todRxSeconds(rxs),
        .markerOutputPair(mop), .markerOutputEn(moe), .todTxLine(tx), .measureOut(meas), .subSecond(sub),
        .secondsNow(secs), .secondTick(tick), .edgeStamp(stamp), .edgeStampValid(esv));
    spt_time_master_model master (.mclk(mclk), .fire(fire), .secVal(sv),
        .markerInputPair(mip), .todRxValid(rxv), .todRxSeconds(rxs));
    initial begin
        forever #20 mclk = ~mclk;
    end
    // Wide enough that a counter and the seconds can be compared in one go.
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        num_checks++;
        if (got !== exp) begin
            err_count++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic step(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask : step
    // Waits at most two seconds of the shortened counter for the rollover tick.
    task automatic wait_tick;
        for (int i = 0; i < 200 && tick !== 1'b1; i++) step(1);
    endtask : wait_tick
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : report_and_stop
    // Rollover in output mode with a given high-time request and expected width.
    task automatic t_rollover(input logic [31:0] req, input int expW);
        @(posedge mclk) begin portDir <= SPT_DIR_OUT; hc <= req; end
        step(1); wait_tick; step(1); s = secs;
        wait_tick;
        chk(secs, s + 32'h1);
        chk({sub, mop, meas}, {32'h0, 2'b11});
        for (w = 0; meas === 1'b1 && w < 400; w++) step(1);
        chk(w, expW);
        $display("rollover test done");
    endtask : t_rollover
    // Message frame: start low, 32 bits LSB first, stop high.
    task automatic t_message;
        wait_tick; s = secs; step(1);
        chk(tx, 1'b0);
        for (int i = 0; i < 32; i++) begin step(2); chk(tx, s[i]); end
        step(2); chk(tx, 1'b1);
        $display("message test done");
    endtask : t_message
    // Incoming edge aligns the counter to the compensation and takes the message.
    task automatic t_input;
        @(posedge mclk) begin portDir <= SPT_DIR_IN; fire <= 1'b1; end
        @(posedge mclk) fire <= 1'b0;
        for (w = 0; esv !== 1'b1 && w < 20; w++) begin s = sub; step(1); end
        chk({sub, secs}, {32'd7, sv});
        chk(stamp, s);
        @(posedge mclk) begin portDir <= SPT_DIR_OUT; fire <= 1'b1; end
        @(posedge mclk) fire <= 1'b0;
        w = 0;
        repeat (12) begin step(1); w += (esv === 1'b1); end
        chk(w, 0);
        $display("input test done");
    endtask : t_input
    // A low clock enable freezes counter and pulse mid-pulse; counting resumes after it.
    task automatic t_freeze;
        @(posedge mclk) hc <= 32'd10;
        wait_tick; step(2);
        @(posedge mclk) clkEn <= 1'b0;
        step(1); s = sub;
        step(5);
        chk({sub, meas}, {s, 1'b1});
        @(posedge mclk) clkEn <= 1'b1;
        step(1);
        chk(sub, s + 32'h1);
        $display("freeze test done");
    endtask : t_freeze
    initial begin
        step(10);
        chk({tx, meas, moe, esv}, 4'b1000);
        @(posedge mclk) rst <= 1'b0;
        t_rollover(32'd10, 10);
        t_rollover(32'd1, 3);
        t_message;
        t_input;
        t_freeze;
        report_and_stop;
    end
    initial begin
        repeat (5000) @(posedge mclk);
        err_count++;
        report_and_stop;
    end
endmodule : testbench
